// ---- common/dsf_pkg.sv ----
`default_nettype none

package dsf_pkg;

  // ==========================================================
  // Sector field bytes and lengths
  localparam logic [7:0] SYNC_BYTE = 8'h66;
  localparam logic [7:0] MARK_LEAD = 8'h71;
  localparam logic [7:0] ID_MARK   = 8'h8e;
  localparam logic [7:0] DATA_MARK = 8'ha3;
  localparam logic [7:0] PAD_BYTE  = 8'h77;
  localparam logic [7:0] GAP_BYTE  = 8'h00;

  localparam int ID_SYNC_LEN   = 9;
  localparam int MARK_LEN      = 2;
  localparam int ID_ADDR_LEN   = 6;
  localparam int ID_CRC_LEN    = 3;
  localparam int PAD_LEN       = 3;
  localparam int DATA_SYNC_LEN = 16;
  localparam int ECC_LEN       = 14;
  localparam int USER_LEN_MIN  = 512;
  localparam int USER_LEN_MAX  = 532;
  localparam int USER_LEN_DEF  = 512;

  localparam int CNT_W    = 10;
  localparam int RUN_W    = 5;
  localparam int ID_W     = 8 * ID_ADDR_LEN;
  localparam int ID_CRC_W = 8 * ID_CRC_LEN;
  localparam int ECC_W    = 8 * ECC_LEN;

  // ==========================================================
  // Recording zones
  localparam int ZONES   = 16;
  localparam int ZONE_W  = 4;
  localparam int SPT_W   = 7;
  localparam int SPT_MIN = 63;
  localparam int SPT_MAX = 106;
  // Zone 0 outermost, zone 15 innermost
  localparam logic [SPT_W-1:0] ZONE_SPT [ZONES] = '{
    7'h6b, 7'h6b, 7'h6b, 7'h6b, 7'h6b, 7'h6a, 7'h66, 7'h62,
    7'h5e, 7'h58, 7'h54, 7'h51, 7'h4f, 7'h4a, 7'h46, 7'h41
  };

  // ==========================================================
  // Defaults for the free parameters
  localparam int GAP_LEN_DEF   = 24;
  localparam int SYNC_QUAL_DEF = 4;
  localparam int HUNT_WIN_DEF  = 48;
  localparam logic [ID_CRC_W-1:0] ID_POLY_DEF  = 24'h86_4cfb;
  localparam logic [ECC_W-1:0]    ECC_POLY_DEF = 112'h0000_0000_0000_0000_0000_0040_0007;

  // ==========================================================
  // Sequencer states
  typedef enum logic [20:0] {
    S_IDLE    = 21'h0_0001,
    S_W_ISYNC = 21'h0_0002,
    S_W_IMARK = 21'h0_0004,
    S_W_IADDR = 21'h0_0008,
    S_W_ICRC  = 21'h0_0010,
    S_W_IPAD  = 21'h0_0020,
    S_W_DSYNC = 21'h0_0040,
    S_W_DMARK = 21'h0_0080,
    S_W_DATA  = 21'h0_0100,
    S_W_ECC   = 21'h0_0200,
    S_W_DPAD  = 21'h0_0400,
    S_W_GAP   = 21'h0_0800,
    S_R_IHUNT = 21'h0_1000,
    S_R_IMARK = 21'h0_2000,
    S_R_IADDR = 21'h0_4000,
    S_R_ICRC  = 21'h0_8000,
    S_R_IPAD  = 21'h1_0000,
    S_R_DHUNT = 21'h2_0000,
    S_R_DMARK = 21'h4_0000,
    S_R_DATA  = 21'h8_0000,
    S_R_ECC   = 21'h10_0000
  } dsf_state_e;

endpackage

`default_nettype wire

// ---- design/dsf_chk.sv ----
`default_nettype none

module dsf_chk #(
  parameter int         W    = dsf_pkg::ID_CRC_W,
  parameter logic [W-1:0] POLY = dsf_pkg::ID_POLY_DEF
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Byte-serial control
  input  wire logic         clr,
  input  wire logic         upd,
  input  wire logic         shf,
  input  wire logic [7:0]   din,
  // Check remainder, top byte first
  output logic      [W-1:0] chk_q
);
  import dsf_pkg::*;

  logic [W-1:0] chk_d;

  if (W < 16 || (W % 8) != 0) begin : g_bad_w
    $error("dsf_chk: W must be a multiple of 8, at least 16");
  end

  // ==========================================================
  // MSB-first division, one byte per clock
  function automatic logic [W-1:0] step(logic [W-1:0] r, logic [7:0] d);
    logic [W-1:0] t;
    logic         fb;
    t = r;
    for (int i = 7; i >= 0; i--) begin
      fb = t[W-1] ^ d[i];
      t  = {t[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    return t;
  endfunction

  always_comb begin
    chk_d = chk_q;
    if (clr) begin
      chk_d = '0;
    end else if (upd) begin
      chk_d = step(chk_q, din);
    end else if (shf) begin
      chk_d = {chk_q[W-9:0], 8'h00};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chk_q <= '0;
    end else begin
      chk_q <= chk_d;
    end
  end

endmodule

`default_nettype wire

// ---- design/dsf_zone_spt.sv ----
`default_nettype none

module dsf_zone_spt (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Zone of the current track
  input  wire logic [dsf_pkg::ZONE_W-1:0] zone,
  // Sectors per track
  output logic      [dsf_pkg::SPT_W-1:0]  spt_q
);
  import dsf_pkg::*;

  logic [SPT_W-1:0] spt_d;

  // Table entries are held inside the legal sector range
  function automatic logic [SPT_W-1:0] clamp_spt(logic [SPT_W-1:0] v);
    if (v > SPT_W'(SPT_MAX)) begin
      return SPT_W'(SPT_MAX);
    end else if (v < SPT_W'(SPT_MIN)) begin
      return SPT_W'(SPT_MIN);
    end
    return v;
  endfunction

  always_comb begin
    spt_d = clamp_spt(ZONE_SPT[zone]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spt_q <= SPT_W'(SPT_MAX);
    end else begin
      spt_q <= spt_d;
    end
  end

endmodule

`default_nettype wire

// ---- design/dsf_sector_fmt.sv ----
`default_nettype none

// Functional notes
// - The ID part opens with nine sync bytes of 66h.
// - An ID mark of 71h then 8Eh follows the ID sync and starts the address on read.
// - Six address bytes name the sector and are handed to the controller for comparison.
// - Three check bytes follow the address and a read mismatch is flagged as a bad ID.
// - The ID part closes with three pad bytes of 77h.
// - The data part opens with sixteen sync bytes of 66h.
// - A data mark of 71h then A3h follows the data sync and starts user data on read.
// - User data has one fixed length, set at build time, from 512 to 532 bytes.
// - Fourteen correction bytes follow the user data.
// - The data part closes with three pad bytes of 77h.
// - Sectors per track lie between 63 and 106, more on outer tracks.
// - Sixteen zones run from 0 outermost to 15 innermost, each with its own count.
// - Sector size and sectors per track are fixed and cannot be changed in the field.
module dsf_sector_fmt #(
  parameter int                          USER_LEN  = dsf_pkg::USER_LEN_DEF,
  parameter int                          GAP_LEN   = dsf_pkg::GAP_LEN_DEF,
  parameter int                          SYNC_QUAL = dsf_pkg::SYNC_QUAL_DEF,
  parameter int                          HUNT_WIN  = dsf_pkg::HUNT_WIN_DEF,
  parameter logic [dsf_pkg::ID_CRC_W-1:0] ID_POLY   = dsf_pkg::ID_POLY_DEF,
  parameter logic [dsf_pkg::ECC_W-1:0]    ECC_POLY  = dsf_pkg::ECC_POLY_DEF
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Controller commands
  input  wire logic                       fmt_start,
  input  wire logic                       wr_start,
  input  wire logic                       rd_start,
  input  wire logic                       rd_id_only,
  input  wire logic                       op_cancel,
  input  wire logic [dsf_pkg::ID_W-1:0]   fmt_id,
  // Write data fetch
  input  wire logic [7:0]                 usr_wr_byte,
  output logic                            usr_wr_act_q,
  output logic      [dsf_pkg::CNT_W-1:0]  usr_wr_idx_q,
  // Track position
  input  wire logic [dsf_pkg::ZONE_W-1:0] zone,
  input  wire logic                       index_mark,
  output logic      [dsf_pkg::SPT_W-1:0]  spt_q,
  output logic      [dsf_pkg::SPT_W-1:0]  sec_idx_q,
  output logic                            track_wrap_q,
  // Channel write side
  output logic                            ch_wr_gate_q,
  output logic      [7:0]                 ch_wr_byte_q,
  // Channel read side
  input  wire logic                       ch_rd_valid,
  input  wire logic [7:0]                 ch_rd_byte,
  // Parse results
  output logic      [dsf_pkg::ID_W-1:0]   id_q,
  output logic                            id_valid_q,
  output logic                            id_err_q,
  output logic                            usr_rd_valid_q,
  output logic      [7:0]                 usr_rd_byte_q,
  output logic                            data_err_q,
  output logic                            pad_err_q,
  output logic                            done_q,
  output logic                            abort_q,
  output logic                            busy_q
);
  import dsf_pkg::*;

  // ==========================================================
  // Build-time checks
  if (USER_LEN < USER_LEN_MIN || USER_LEN > USER_LEN_MAX) begin : g_bad_len
    $error("dsf_sector_fmt: USER_LEN out of range");
  end
  if (SYNC_QUAL < 1 || SYNC_QUAL > ID_SYNC_LEN) begin : g_bad_qual
    $error("dsf_sector_fmt: SYNC_QUAL out of range");
  end
  if (HUNT_WIN <= DATA_SYNC_LEN || HUNT_WIN >= (1 << CNT_W)) begin : g_bad_win
    $error("dsf_sector_fmt: HUNT_WIN out of range");
  end
  if (GAP_LEN < 1 || GAP_LEN >= (1 << CNT_W)) begin : g_bad_gap
    $error("dsf_sector_fmt: GAP_LEN out of range");
  end

  localparam logic [CNT_W-1:0] L_ISYNC = CNT_W'(ID_SYNC_LEN - 1);
  localparam logic [CNT_W-1:0] L_MARK  = CNT_W'(MARK_LEN - 1);
  localparam logic [CNT_W-1:0] L_ADDR  = CNT_W'(ID_ADDR_LEN - 1);
  localparam logic [CNT_W-1:0] L_CRC   = CNT_W'(ID_CRC_LEN - 1);
  localparam logic [CNT_W-1:0] L_PAD   = CNT_W'(PAD_LEN - 1);
  localparam logic [CNT_W-1:0] L_DSYNC = CNT_W'(DATA_SYNC_LEN - 1);
  localparam logic [CNT_W-1:0] L_USER  = CNT_W'(USER_LEN - 1);
  localparam logic [CNT_W-1:0] L_ECC   = CNT_W'(ECC_LEN - 1);
  localparam logic [CNT_W-1:0] L_GAP   = CNT_W'(GAP_LEN - 1);
  localparam logic [CNT_W-1:0] L_HUNT  = CNT_W'(HUNT_WIN - 1);
  localparam logic [RUN_W-1:0] RUN_OK  = RUN_W'(SYNC_QUAL);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] id_byte(logic [ID_W-1:0] id, logic [CNT_W-1:0] i);
    return id[ID_W - 8 * (int'(i) + 1) +: 8];
  endfunction

  function automatic logic rd_state(dsf_state_e s);
    return s inside {S_R_IHUNT, S_R_IMARK, S_R_IADDR, S_R_ICRC, S_R_IPAD,
                     S_R_DHUNT, S_R_DMARK, S_R_DATA, S_R_ECC};
  endfunction

  // ==========================================================
  // State
  dsf_state_e        st_q, st_d;
  logic [CNT_W-1:0]  cnt_d, idx_d;
  logic [RUN_W-1:0]  run_q, run_d;
  logic              bad_q, bad_d, idonly_q, idonly_d;
  logic              act_d, gate_d, idv_d, iderr_d, rv_d, derr_d, paderr_d;
  logic              done_d, abort_d, busy_d;
  logic [7:0]        wbyte_d, rbyte_d;
  logic [ID_W-1:0]   id_d;
  logic [CNT_W-1:0]  cnt_q;
  logic              adv, last;
  logic              id_clr, id_upd, id_shf, ecc_clr, ecc_upd, ecc_shf;
  logic [7:0]        id_din, ecc_din;
  logic [ID_CRC_W-1:0] id_chk;
  logic [ECC_W-1:0]    ecc_chk;
  logic [7:0]        id_top, ecc_top;

  assign id_top  = id_chk[ID_CRC_W-1 -: 8];
  assign ecc_top = ecc_chk[ECC_W-1 -: 8];

  // Read and write never overlap, so one checker per field serves both
  dsf_chk #(.W(ID_CRC_W), .POLY(ID_POLY)) u_id_chk (
    .clk   (clk),
    .reset (reset),
    .clr   (id_clr),
    .upd   (id_upd),
    .shf   (id_shf),
    .din   (id_din),
    .chk_q (id_chk)
  );

  dsf_chk #(.W(ECC_W), .POLY(ECC_POLY)) u_ecc_chk (
    .clk   (clk),
    .reset (reset),
    .clr   (ecc_clr),
    .upd   (ecc_upd),
    .shf   (ecc_shf),
    .din   (ecc_din),
    .chk_q (ecc_chk)
  );

  dsf_zone_spt u_zone (
    .clk   (clk),
    .reset (reset),
    .zone  (zone),
    .spt_q (spt_q)
  );

  // ==========================================================
  // Sector sequencer
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    run_d    = run_q;
    bad_d    = bad_q;
    idonly_d = idonly_q;
    id_d     = id_q;
    rbyte_d  = usr_rd_byte_q;
    wbyte_d  = GAP_BYTE;
    gate_d   = 1'b0;
    idv_d    = 1'b0;
    iderr_d  = 1'b0;
    rv_d     = 1'b0;
    derr_d   = 1'b0;
    paderr_d = 1'b0;
    done_d   = 1'b0;
    abort_d  = 1'b0;
    last     = 1'b0;
    adv      = rd_state(st_q) ? ch_rd_valid : (st_q != S_IDLE);
    id_clr   = 1'b0;
    id_upd   = 1'b0;
    id_shf   = 1'b0;
    id_din   = ch_rd_byte;
    ecc_clr  = 1'b0;
    ecc_upd  = 1'b0;
    ecc_shf  = 1'b0;
    ecc_din  = ch_rd_byte;
    case (st_q)
      S_IDLE: begin
        cnt_d = '0;
        run_d = '0;
        bad_d = 1'b0;
        if (fmt_start) begin
          st_d = S_W_ISYNC;
        end else if (wr_start) begin
          st_d = S_W_DSYNC;
        end else if (rd_start) begin
          st_d     = S_R_IHUNT;
          idonly_d = rd_id_only;
        end
      end
      S_W_ISYNC: begin
        gate_d  = 1'b1;
        wbyte_d = SYNC_BYTE;
        last    = (cnt_q == L_ISYNC);
        if (last) st_d = S_W_IMARK;
      end
      S_W_IMARK: begin
        gate_d  = 1'b1;
        wbyte_d = (cnt_q == '0) ? MARK_LEAD : ID_MARK;
        id_clr  = 1'b1;
        last    = (cnt_q == L_MARK);
        if (last) st_d = S_W_IADDR;
      end
      S_W_IADDR: begin
        gate_d  = 1'b1;
        wbyte_d = id_byte(fmt_id, cnt_q);
        id_din  = wbyte_d;
        id_upd  = 1'b1;
        last    = (cnt_q == L_ADDR);
        if (last) st_d = S_W_ICRC;
      end
      S_W_ICRC: begin
        gate_d  = 1'b1;
        wbyte_d = id_top;
        id_shf  = 1'b1;
        last    = (cnt_q == L_CRC);
        if (last) st_d = S_W_IPAD;
      end
      S_W_IPAD: begin
        gate_d  = 1'b1;
        wbyte_d = PAD_BYTE;
        last    = (cnt_q == L_PAD);
        if (last) st_d = S_W_DSYNC;
      end
      S_W_DSYNC: begin
        gate_d  = 1'b1;
        wbyte_d = SYNC_BYTE;
        ecc_clr = 1'b1;
        last    = (cnt_q == L_DSYNC);
        if (last) st_d = S_W_DMARK;
      end
      S_W_DMARK: begin
        gate_d  = 1'b1;
        wbyte_d = (cnt_q == '0) ? MARK_LEAD : DATA_MARK;
        last    = (cnt_q == L_MARK);
        if (last) st_d = S_W_DATA;
      end
      S_W_DATA: begin
        gate_d  = 1'b1;
        wbyte_d = usr_wr_byte;
        ecc_din = usr_wr_byte;
        ecc_upd = 1'b1;
        last    = (cnt_q == L_USER);
        if (last) st_d = S_W_ECC;
      end
      S_W_ECC: begin
        gate_d  = 1'b1;
        wbyte_d = ecc_top;
        ecc_shf = 1'b1;
        last    = (cnt_q == L_ECC);
        if (last) st_d = S_W_DPAD;
      end
      S_W_DPAD: begin
        gate_d  = 1'b1;
        wbyte_d = PAD_BYTE;
        last    = (cnt_q == L_PAD);
        if (last) st_d = S_W_GAP;
      end
      S_W_GAP: begin
        // Gate held through the gap so the head current ends cleanly
        gate_d = 1'b1;
        last   = (cnt_q == L_GAP);
        if (last) begin
          st_d   = S_IDLE;
          done_d = 1'b1;
        end
      end
      S_R_IHUNT, S_R_DHUNT: begin
        id_clr  = 1'b1;
        ecc_clr = 1'b1;
        bad_d   = 1'b0;
        if (ch_rd_valid) begin
          if (ch_rd_byte == SYNC_BYTE) begin
            run_d = (run_q == RUN_OK) ? run_q : run_q + 1'b1;
          end else if (run_q == RUN_OK && ch_rd_byte == MARK_LEAD) begin
            last = 1'b1;
            st_d = (st_q == S_R_IHUNT) ? S_R_IMARK : S_R_DMARK;
          end else if (run_q == RUN_OK) begin
            st_d    = S_IDLE;
            abort_d = 1'b1;
          end else begin
            run_d = '0;
          end
          if (!last && cnt_q == L_HUNT) begin
            st_d    = S_IDLE;
            abort_d = 1'b1;
          end
        end
      end
      S_R_IMARK, S_R_DMARK: begin
        last = 1'b1;
        run_d = '0;
        if (ch_rd_valid) begin
          if (st_q == S_R_IMARK && ch_rd_byte == ID_MARK) begin
            st_d = S_R_IADDR;
          end else if (st_q == S_R_DMARK && ch_rd_byte == DATA_MARK) begin
            st_d = S_R_DATA;
          end else begin
            st_d    = S_IDLE;
            abort_d = 1'b1;
          end
        end
      end
      S_R_IADDR: begin
        id_upd = ch_rd_valid;
        last   = (cnt_q == L_ADDR);
        if (ch_rd_valid) begin
          id_d = {id_q[ID_W-9:0], ch_rd_byte};
          if (last) st_d = S_R_ICRC;
        end
      end
      S_R_ICRC: begin
        id_shf = ch_rd_valid;
        last   = (cnt_q == L_CRC);
        if (ch_rd_valid) begin
          bad_d = bad_q | (ch_rd_byte != id_top);
          if (last) begin
            // A bad ID abandons the sector
            iderr_d = bad_d;
            idv_d   = !bad_d;
            done_d  = !bad_d && idonly_q;
            st_d    = (bad_d || idonly_q) ? S_IDLE : S_R_IPAD;
          end
        end
      end
      S_R_IPAD: begin
        last = (cnt_q == L_PAD);
        if (ch_rd_valid) begin
          paderr_d = (ch_rd_byte != PAD_BYTE);
          if (last) st_d = S_R_DHUNT;
        end
      end
      S_R_DATA: begin
        ecc_upd = ch_rd_valid;
        last    = (cnt_q == L_USER);
        if (ch_rd_valid) begin
          rv_d    = 1'b1;
          rbyte_d = ch_rd_byte;
          if (last) st_d = S_R_ECC;
        end
      end
      S_R_ECC: begin
        ecc_shf = ch_rd_valid;
        last    = (cnt_q == L_ECC);
        if (ch_rd_valid) begin
          bad_d = bad_q | (ch_rd_byte != ecc_top);
          if (last) begin
            derr_d = bad_d;
            done_d = 1'b1;
            st_d   = S_IDLE;
          end
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    if (adv && st_q != S_IDLE) begin
      cnt_d = last ? '0 : cnt_q + 1'b1;
    end
    if (op_cancel && st_q != S_IDLE) begin
      st_d    = S_IDLE;
      gate_d  = 1'b0;
      done_d  = 1'b0;
      abort_d = 1'b1;
    end
    act_d  = (st_d == S_W_DATA);
    idx_d  = act_d ? cnt_d : '0;
    busy_d = (st_d != S_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q           <= S_IDLE;
      cnt_q          <= '0;
      run_q          <= '0;
      bad_q          <= 1'b0;
      idonly_q       <= 1'b0;
      id_q           <= '0;
      usr_wr_act_q   <= 1'b0;
      usr_wr_idx_q   <= '0;
      ch_wr_gate_q   <= 1'b0;
      ch_wr_byte_q   <= GAP_BYTE;
      id_valid_q     <= 1'b0;
      id_err_q       <= 1'b0;
      usr_rd_valid_q <= 1'b0;
      usr_rd_byte_q  <= 8'h00;
      data_err_q     <= 1'b0;
      pad_err_q      <= 1'b0;
      done_q         <= 1'b0;
      abort_q        <= 1'b0;
      busy_q         <= 1'b0;
    end else begin
      st_q           <= st_d;
      cnt_q          <= cnt_d;
      run_q          <= run_d;
      bad_q          <= bad_d;
      idonly_q       <= idonly_d;
      id_q           <= id_d;
      usr_wr_act_q   <= act_d;
      usr_wr_idx_q   <= idx_d;
      ch_wr_gate_q   <= gate_d;
      ch_wr_byte_q   <= wbyte_d;
      id_valid_q     <= idv_d;
      id_err_q       <= iderr_d;
      usr_rd_valid_q <= rv_d;
      usr_rd_byte_q  <= rbyte_d;
      data_err_q     <= derr_d;
      pad_err_q      <= paderr_d;
      done_q         <= done_d;
      abort_q        <= abort_d;
      busy_q         <= busy_d;
    end
  end

  // ==========================================================
  // Sector position within the track
  logic [SPT_W-1:0] sec_d;
  logic             wrap_d;

  always_comb begin
    sec_d  = sec_idx_q;
    wrap_d = 1'b0;
    if (index_mark) begin
      sec_d = '0;
    end else if (done_d) begin
      // Count only; the sector count itself is fixed by zone
      if (sec_idx_q >= spt_q - 1'b1) begin
        sec_d  = '0;
        wrap_d = 1'b1;
      end else begin
        sec_d = sec_idx_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sec_idx_q    <= '0;
      track_wrap_q <= 1'b0;
    end else begin
      sec_idx_q    <= sec_d;
      track_wrap_q <= wrap_d;
    end
  end

endmodule

`default_nettype wire

// ---- dv/dsf_sector_fmt_checker.sv ----
`default_nettype none

module dsf_sector_fmt_checker
  import dsf_pkg::*;
#(
  parameter int USER_LEN = dsf_pkg::USER_LEN_DEF
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // Commands
  input wire logic                       fmt_start,
  input wire logic                       wr_start,
  input wire logic                       rd_start,
  input wire logic [dsf_pkg::ID_W-1:0]   fmt_id,
  input wire logic [dsf_pkg::ZONE_W-1:0] zone,
  // Observed results
  input wire logic                       usr_wr_act_q,
  input wire logic [dsf_pkg::CNT_W-1:0]  usr_wr_idx_q,
  input wire logic [dsf_pkg::SPT_W-1:0]  spt_q,
  input wire logic                       ch_wr_gate_q,
  input wire logic [7:0]                 ch_wr_byte_q,
  input wire logic                       id_err_q,
  input wire logic                       done_q,
  input wire logic                       abort_q,
  input wire logic                       busy_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========
  // Cycles since start
  localparam int DPAD = USER_LEN + 57;
  logic        tk;
  logic [7:0]  b;
  logic [10:0] cnt_q, cnt_d;
  logic        fmt_q, fmt_d;
  assign tk = !busy_q && (fmt_start || wr_start || rd_start);
  assign b  = ch_wr_byte_q;
  always_comb begin
    cnt_d = tk ? 11'h001 : cnt_q + 11'h001;
    fmt_d = tk ? fmt_start : fmt_q;
  end
  always_ff @(posedge clk) begin
    cnt_q <= reset ? 11'h000 : cnt_d;
    fmt_q <= reset ? 1'b0 : fmt_d;
  end

  // ==========
  // Properties
  property p_fmt_sync;
    tk && fmt_start |=> ##1 (b == SYNC_BYTE)[*8] ##1 b == SYNC_BYTE ##1 b == MARK_LEAD
      ##1 b == ID_MARK;
  endproperty
  a_fmt_sync: assert property (p_fmt_sync) else $error("id sync");
  property p_wr_sync;
    tk && wr_start && !fmt_start |=> ##1 (b == SYNC_BYTE)[*8] ##1 (b == SYNC_BYTE)[*8]
      ##1 b == MARK_LEAD ##1 b == DATA_MARK;
  endproperty
  a_wr_sync: assert property (p_wr_sync) else $error("data sync");
  property p_id_addr;
    tk && fmt_start |-> ##13 b == fmt_id[47:40] ##5 b == fmt_id[7:0];
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id address");
  property p_id_pad;
    tk && fmt_start |-> ##22 (b == PAD_BYTE)[*3] ##1 b == SYNC_BYTE;
  endproperty
  a_id_pad: assert property (p_id_pad) else $error("id pad");
  property p_data_len;
    $fell(usr_wr_act_q) |-> $past(usr_wr_idx_q) == 10'(USER_LEN - 1);
  endproperty
  a_data_len: assert property (p_data_len) else $error("user length");
  property p_ecc_pad;
    ch_wr_gate_q && cnt_q == 11'(fmt_q ? DPAD : DPAD - 23) |-> (b == PAD_BYTE)[*3]
      ##1 b == GAP_BYTE;
  endproperty
  a_ecc_pad: assert property (p_ecc_pad) else $error("data pad");
  property p_spt_rng;
    spt_q >= 7'h3f && spt_q <= 7'h6a;
  endproperty
  a_spt_rng: assert property (p_spt_rng) else $error("spt range");
  property p_spt_ord;
    zone > $past(zone) |=> spt_q <= $past(spt_q);
  endproperty
  a_spt_ord: assert property (p_spt_ord) else $error("spt order");
  property p_id_err;
    id_err_q |-> !done_q && !abort_q ##1 !busy_q;
  endproperty
  a_id_err: assert property (p_id_err) else $error("id error");
endmodule

bind dsf_sector_fmt dsf_sector_fmt_checker #(.USER_LEN(USER_LEN)) u_chk (.*);

`default_nettype wire

// ---- dv/dsf_chan_model.sv ----
`default_nettype none

module dsf_chan_model (
  // Clock
  input wire logic        clk,
  // Write side from the formatter
  input wire logic        ch_wr_gate_q,
  input wire logic [7:0]  ch_wr_byte_q,
  // Playback control
  input wire logic        play,
  input wire logic        slow,
  input wire logic [10:0] bad_at,
  // Read side to the formatter
  output logic            ch_rd_valid,
  output logic [7:0]      ch_rd_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Records a burst, replays it
  logic [7:0] mem [2048];
  int         n = 0, pos = 0;
  logic       act = 0, ph = 0, pg = 0;
  logic [7:0] last = 8'h00;
  always @(posedge clk) begin
    if (ch_wr_gate_q) begin
      mem[pg ? n : 0] <= ch_wr_byte_q;
      n <= pg ? n + 1 : 1;
    end
    pg <= ch_wr_gate_q;
    ph <= !ph;
    if (play) begin
      act <= 1'b1;
      pos <= 0;
    end else if (ch_rd_valid) begin
      last <= ch_rd_byte;
      pos <= pos + 1;
      if (pos + 1 >= n) act <= 1'b0;
    end
  end
  assign ch_rd_valid = act && (!slow || ph);
  // Idle shows inverse of last
  assign ch_rd_byte = ch_rd_valid ? mem[pos] ^ {7'h00, pos == bad_at} : ~last;
endmodule

`default_nettype wire

// ---- dv/dsf_sector_fmt_tb.sv ----
`default_nettype none

module dsf_sector_fmt_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dsf_pkg::*;
  localparam int U = 512;
  logic clk = 0, reset = 1, fmt_start = 0, wr_start = 0, rd_start = 0, rd_id_only = 0;
  logic op_cancel = 0, index_mark = 0, play = 0, slow = 0;
  logic [47:0] fmt_id = '0, id_q;
  logic [3:0]  zone = '0;
  logic [10:0] bad_at = 11'h7ff;
  logic [7:0]  ubuf [U];
  logic [7:0]  usr_wr_byte, ch_wr_byte_q, ch_rd_byte, usr_rd_byte_q;
  logic [9:0]  usr_wr_idx_q;
  logic [6:0]  spt_q, sec_idx_q;
  logic usr_wr_act_q, track_wrap_q, ch_wr_gate_q, ch_rd_valid, id_valid_q, id_err_q;
  logic usr_rd_valid_q, data_err_q, pad_err_q, done_q, abort_q, busy_q;
  logic [31:0] rs = 32'h0001_2c2d;
  int num_errors = 0, compares = 0, rk = 0;
  int ev [5] = '{5{0}};
  assign usr_wr_byte = ubuf[usr_wr_idx_q];

  dsf_sector_fmt #(.USER_LEN(U), .GAP_LEN(GAP_LEN_DEF)) dut (.*);
  dsf_chan_model chan (.*);

  initial forever #25 clk = ~clk;

  // ==========
  // Helpers
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Bit 8: not predicted
  function automatic logic [8:0] xb(int i, logic f);
    int j = f ? i : i + 23;
    if (j < 9 || (j > 22 && j < 39)) return 9'h066;
    if (j == 9 || j == 39) return 9'h071;
    if (j == 10) return 9'h08e;
    if (j == 40) return 9'h0a3;
    if (j < 17) return {1'b0, fmt_id[8*(16-j) +: 8]};
    if (j < 20) return 9'h100;
    if (j < 23) return 9'h077;
    if (j < 41 + U) return {1'b0, ubuf[j-41]};
    if (j < 55 + U) return 9'h100;
    if (j < 58 + U) return 9'h077;
    return 9'h000;
  endfunction
  task automatic chk(logic [47:0] s, e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %0t %h %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic go(logic f, logic w, logic r, logic p);
    @(posedge clk);
    {fmt_start, wr_start, rd_start, play} <= {f, w, r, p};
    @(posedge clk);
    {fmt_start, wr_start, rd_start, play} <= 4'h0;
  endtask
  task automatic wait_idle();
    int k = 0;
    @(posedge clk);
    #1;
    while (busy_q !== 1'b0 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 3000) begin
      num_errors++;
      print_verdict();
    end
    repeat (70) @(posedge clk);
    $display("step done %0t", $time);
  endtask
  always @(posedge clk) begin
    ev[0] += id_valid_q === 1'b1;
    ev[1] += id_err_q === 1'b1;
    ev[2] += done_q === 1'b1;
    ev[3] += data_err_q === 1'b1;
    ev[4] += abort_q === 1'b1;
    if (usr_rd_valid_q === 1'b1) begin
      chk(usr_rd_byte_q, ubuf[rk]);
      rk++;
    end
  end

  // ==========
  // Scenarios
  task automatic write_sector(logic f, logic [47:0] id);
    int i;
    logic [8:0] e;
    fmt_id <= id;
    for (i = 0; i < U; i++) ubuf[i] = 8'(xs());
    go(f, !f, 1'b0, 1'b0);
    wait_idle();
    chk(chan.n, 35 + U + GAP_LEN_DEF + (f ? 23 : 0));
    for (i = 0; i < chan.n; i++) begin
      e = xb(i, f);
      if (!e[8]) chk(chan.mem[i], e[7:0]);
    end
  endtask
  task automatic read_sector(int x[5], logic s = 0, logic io = 0, logic [10:0] bad = 11'h7ff);
    int b[5] = ev;
    rk = 0;
    slow <= s;
    bad_at <= bad;
    rd_id_only <= io;
    go(1'b0, 1'b0, 1'b1, 1'b1);
    wait_idle();
    for (int k = 0; k < 5; k++) if (x[k] >= 0) chk(ev[k] - b[k], x[k]);
    if (x[0] == 1) chk(id_q, fmt_id);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int z = 0; z < 16; z++) begin
      @(posedge clk);
      zone <= 4'(z);
      repeat (2) @(posedge clk);
      #1;
      chk(spt_q, ZONE_SPT[z] > SPT_MAX ? SPT_MAX : ZONE_SPT[z]);
    end
    write_sector(1'b1, 48'hffff_ffff_ffff);
    read_sector('{1, 0, 1, 0, 0});
    read_sector('{1, 0, 1, 0, 0}, 1);
    read_sector('{0, 1, 0, 0, 0}, 0, 0, 11'h012);
    read_sector('{1, 0, 1, 1, 0}, 1, 0, 11'h22b);
    read_sector('{1, 0, -1, 0, 0}, 0, 1);
    for (int r = 0; r < 2; r++) begin
      write_sector(1'b1, {16'(xs()), xs()});
      read_sector('{1, 0, 1, 0, 0}, 1'(xs()));
    end
    write_sector(1'b0, 48'h0000_0000_0000);
    read_sector('{0, 0, 0, 0, 1});
    go(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (30) @(posedge clk);
    op_cancel <= 1'b1;
    @(posedge clk);
    op_cancel <= 1'b0;
    wait_idle();
    chk(busy_q, 1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
